// *** otp_program_and_lock_access.sv ***
/*
 * Programming, verify, lock-bit and signature access to the on-chip
 * one-time-programmable code memory, plus run-time lock protection outputs.
 * Assumes an external programmer drives the pins, holds them stable for the
 * program pulse, and that all pins are asynchronous to ref_clk_in.
 */
// Operation
// - Ports one and two give the address
// - Port zero carries write data and read-back
// - Decode operation from reset, strobe, pulse, selects
// - Signature bytes at 30H, 31H, 32H
// - Three independent lock bits, four levels
// - No lock bits: nothing is protected
// - Lock one blocks external table reads
// - Lock one latches access pin at reset
// - Lock one refuses further code writes
// - Locks one and two refuse verify
// - All locks block external execution
`timescale 1ns/1ps
`include "otp_prog_defs.svh"
module otp_program_and_lock_access #(
    parameter int        ADDR_W      = 13,
    parameter logic [7:0] SIG_MAKER  = 8'h5a,  // Arbitrary value.
    parameter logic [7:0] SIG_KIND   = 8'ha5,  // Arbitrary value.
    parameter logic [7:0] SIG_EXTRA  = 8'h3c   // Arbitrary value.
) (
    input  wire logic       ref_clk_in,                     // System clock, 50 MHz.
    input  wire logic       rst_in,                         // Synchronous reset, active high.
    input  wire logic       reset_pin_in,                   // Device reset pin level.
    input  wire logic       program_strobe_enable_in,       // Strobe enable pin level.
    input  wire logic       latch_program_pulse_in,         // Latch/program pin, low pulse programs.
    input  wire logic       external_access_prog_voltage_in,// High-voltage detect on access pin.
    input  wire logic       external_access_pin_in,         // Logic level of access pin.
    input  wire logic       mode_select_a_in,               // Mode select a.
    input  wire logic       mode_select_b_in,               // Mode select b.
    input  wire logic       mode_select_c_in,               // Mode select c.
    input  wire logic       mode_select_d_in,               // Mode select d.
    input  wire logic [7:0] port1_in,                       // Address low byte.
    input  wire logic [7:0] port2_in,                       // Address high bits.
    input  wire logic [7:0] port0_in,                       // Port zero input.
    output logic      [7:0] port0_out,                      // Port zero drive value.
    output logic            port0_oe_out,                   // Port zero drive enable.
    input  wire logic       table_read_from_external_in,    // Table read issued from external code.
    input  wire logic       core_reset_release_in,          // Pulse: core leaves reset.
    output logic            table_read_allowed_out,         // Internal table read permitted.
    output logic            external_access_eff_out,        // Effective access level.
    output logic            external_exec_allowed_out,      // External execution permitted.
    output logic [2:0]      lock_bits_out,                  // Programmed lock bits.
    output logic            write_refused_out,              // Sticky: a write was refused.
    output logic            busy_out                        // Program pulse in progress.
);
    localparam int PULSE_MIN = `OTP_PULSE_MIN_CYC;
    localparam int PULSE_MAX = `OTP_PULSE_MAX_CYC;
    localparam int CNT_W     = $clog2(PULSE_MAX + 2);

    initial begin
        if (ADDR_W < 7 || ADDR_W > 16) begin
            $error("otp_program_and_lock_access: ADDR_W out of range");
        end
    end

    // Synchronise every pin before use.
    localparam int PIN_W = 9 + 8 + 8 + 8;
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;

    assign pins_raw = {reset_pin_in, program_strobe_enable_in, latch_program_pulse_in,
                       external_access_prog_voltage_in, external_access_pin_in,
                       mode_select_a_in, mode_select_b_in, mode_select_c_in, mode_select_d_in,
                       port2_in, port1_in, port0_in};

    otp_pin_sync #(.WIDTH(PIN_W)) u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .async_in   (pins_raw),
        .sync_out   (pins_s)
    );

    otp_prog_pkg::prog_pins_t pins;
    logic [7:0]               addr_hi_s;
    logic [7:0]               addr_lo_s;
    logic [7:0]               data_s;

    assign pins      = otp_prog_pkg::prog_pins_t'(pins_s[PIN_W-1:24]);
    assign addr_hi_s = pins_s[23:16];
    assign addr_lo_s = pins_s[15:8];
    assign data_s    = pins_s[7:0];

    // Address from ports one and two.
    logic [ADDR_W-1:0] prog_addr;
    assign prog_addr = ADDR_W'({addr_hi_s, addr_lo_s});

    // Mode decode.
    wire in_prog_env  = pins.reset_high && !pins.strobe_enable;
    wire sel_wr_code  = pins.mode_select == `OTP_SEL_WRITE_CODE;
    wire sel_rd_code  = pins.mode_select == `OTP_SEL_READ_CODE;
    wire sel_lock_one = pins.mode_select == `OTP_SEL_LOCK_ONE;
    wire sel_lock_two = pins.mode_select == `OTP_SEL_LOCK_TWO;
    wire sel_lock_thr = pins.mode_select == `OTP_SEL_LOCK_THREE;
    wire sel_sig      = pins.mode_select == `OTP_SEL_SIGNATURE;
    wire sel_lock     = sel_lock_one || sel_lock_two || sel_lock_thr;
    wire hv           = pins.prog_voltage;
    wire rd_levels    = pins.latch_program_pulse && pins.access_high && !hv;

    otp_prog_pkg::prog_op_t op;
    assign op = !in_prog_env           ? otp_prog_pkg::OP_IDLE :
                (sel_wr_code && hv)    ? otp_prog_pkg::OP_WRITE_CODE :
                (sel_lock && hv)       ? otp_prog_pkg::OP_WRITE_LOCK :
                (sel_rd_code && rd_levels) ? otp_prog_pkg::OP_READ_CODE :
                (sel_sig && rd_levels) ? otp_prog_pkg::OP_READ_SIG :
                otp_prog_pkg::OP_IDLE;

    // Lock state and protection levels.
    logic [2:0] lock_q;
    logic [2:0] lock_d;
    wire lock_one = lock_q[`OTP_LOCK_ONE_POS];
    wire lock_two = lock_q[`OTP_LOCK_TWO_POS];
    wire lock_thr = lock_q[`OTP_LOCK_THREE_POS];

    otp_prog_pkg::protect_t prot;
    assign prot.block_table_read    = lock_one;
    assign prot.ext_access_latched  = lock_one;
    assign prot.block_write         = lock_one;
    assign prot.block_verify        = lock_one && lock_two;
    assign prot.block_external_exec = lock_one && lock_two && lock_thr;

    // Program pulse measurement: falling edge of the pulse pin starts, rising commits.
    typedef enum logic [1:0] {PS_IDLE, PS_PULSE, PS_WAIT_HIGH} pulse_st_t;
    pulse_st_t        pst_q;
    pulse_st_t        pst_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             prog_low_q;

    wire write_op  = (op == otp_prog_pkg::OP_WRITE_CODE) || (op == otp_prog_pkg::OP_WRITE_LOCK);
    wire pulse_low = !pins.latch_program_pulse;
    wire fall      = pulse_low && !prog_low_q;
    wire rise      = !pulse_low && prog_low_q;
    wire sat       = cnt_q == CNT_W'(PULSE_MAX + 1);
    // Pulses shorter than the minimum are discarded as glitches; long ones still program.
    wire commit    = (pst_q == PS_PULSE) && rise && write_op && cnt_q >= CNT_W'(PULSE_MIN);

    always_comb begin
        pst_d = pst_q;
        cnt_d = cnt_q;
        unique case (pst_q)
            PS_IDLE: begin
                if (fall && write_op) begin
                    pst_d = PS_PULSE;
                    cnt_d = CNT_W'(1);
                end
            end
            PS_PULSE: begin
                if (!write_op) begin
                    pst_d = PS_WAIT_HIGH;
                end else if (rise) begin
                    pst_d = PS_IDLE;
                end else if (!sat) begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            PS_WAIT_HIGH: begin
                if (!pulse_low) begin
                    pst_d = PS_IDLE;
                end
            end
        endcase
    end

    wire code_commit = commit && (op == otp_prog_pkg::OP_WRITE_CODE);
    wire code_ok     = code_commit && !prot.block_write;
    wire lock_commit = commit && (op == otp_prog_pkg::OP_WRITE_LOCK);

    assign lock_d = lock_q | (lock_commit ? {sel_lock_thr, sel_lock_two, sel_lock_one} : 3'h0);

    // Code memory.
    logic [7:0] mem_rd;
    otp_code_mem #(.ADDR_W(ADDR_W), .DATA_W(8)) u_mem (
        .ref_clk_in  (ref_clk_in),
        .wr_en_in    (code_ok),
        .wr_addr_in  (prog_addr),
        .wr_data_in  (data_s),
        .rd_addr_in  (prog_addr),
        .rd_data_out (mem_rd)
    );

    // Signature bytes and read-back path.
    logic [7:0] sig_byte;
    assign sig_byte = (prog_addr == ADDR_W'(`OTP_SIG_ADDR_0)) ? SIG_MAKER :
                      (prog_addr == ADDR_W'(`OTP_SIG_ADDR_1)) ? SIG_KIND  :
                      (prog_addr == ADDR_W'(`OTP_SIG_ADDR_2)) ? SIG_EXTRA : 8'hff;

    wire rd_code_ok = (op == otp_prog_pkg::OP_READ_CODE) && !prot.block_verify;
    wire rd_sig     = op == otp_prog_pkg::OP_READ_SIG;
    logic [7:0] p0_d;
    assign p0_d = rd_sig ? sig_byte : (rd_code_ok ? mem_rd : 8'hff);

    // Access level latched at every core reset release; the latched value is used only when lock one is set.
    logic ea_latch_q;
    logic refused_q;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pst_q        <= PS_IDLE;
            cnt_q        <= '0;
            prog_low_q   <= 1'b0;
            lock_q       <= `OTP_LOCK_RESET;
            ea_latch_q   <= 1'b0;
            refused_q    <= 1'b0;
            port0_out    <= 8'hff;
            port0_oe_out <= 1'b0;
        end else begin
            pst_q        <= pst_d;
            cnt_q        <= cnt_d;
            prog_low_q   <= pulse_low;
            lock_q       <= lock_d;
            port0_out    <= p0_d;
            port0_oe_out <= rd_code_ok || rd_sig;
            if (core_reset_release_in) begin
                ea_latch_q <= pins.access_high;
            end
            if (code_commit && prot.block_write) begin
                refused_q <= 1'b1;
            end
        end
    end

    // Run-time protection outputs; with no lock bits all are permissive.
    assign table_read_allowed_out    = !(prot.block_table_read && table_read_from_external_in);
    assign external_access_eff_out   = prot.ext_access_latched ? ea_latch_q : pins.access_high;
    assign external_exec_allowed_out = !prot.block_external_exec;
    assign lock_bits_out             = lock_q;
    assign write_refused_out         = refused_q;
    assign busy_out                  = pst_q == PS_PULSE;
endmodule

// *** otp_prog_defs.svh ***
/*
 * Constants of the one-time-programmable memory access block: timing, signature
 * locations, lock-bit positions and mode-select patterns.
 * Assumes inclusion by its bare name from the modules that use it.
 */
`ifndef OTP_PROG_DEFS_SVH
`define OTP_PROG_DEFS_SVH

// Clock rate in kHz and the program pulse figures in microseconds.
`define OTP_CLK_KHZ          50000
`define OTP_PULSE_MIN_US     95
`define OTP_PULSE_MAX_US     105
`define OTP_PULSE_MIN_CYC    ((`OTP_PULSE_MIN_US * `OTP_CLK_KHZ + 999) / 1000)
`define OTP_PULSE_MAX_CYC    ((`OTP_PULSE_MAX_US * `OTP_CLK_KHZ) / 1000)

// Signature locations.
`define OTP_SIG_ADDR_0       13'h0030
`define OTP_SIG_ADDR_1       13'h0031
`define OTP_SIG_ADDR_2       13'h0032

// Lock bit positions inside the lock vector.
`define OTP_LOCK_ONE_POS     0
`define OTP_LOCK_TWO_POS     1
`define OTP_LOCK_THREE_POS   2
`define OTP_LOCK_RESET       3'h0

// Mode select patterns, ordered {a, b, c, d}.
`define OTP_SEL_WRITE_CODE   4'h7
`define OTP_SEL_READ_CODE    4'h3
`define OTP_SEL_LOCK_ONE     4'hf
`define OTP_SEL_LOCK_TWO     4'hc
`define OTP_SEL_LOCK_THREE   4'ha
`define OTP_SEL_SIGNATURE    4'h0

`endif

// *** otp_prog_pkg.sv ***
/*
 * Types shared by the one-time-programmable memory access block.
 * Assumes otp_prog_defs.svh is available on the include path.
 */
package otp_prog_pkg;

    typedef enum logic [2:0] {
        OP_IDLE,
        OP_WRITE_CODE,
        OP_READ_CODE,
        OP_WRITE_LOCK,
        OP_READ_SIG
    } prog_op_t;

    // Levels of the programming pins after synchronisation.
    typedef struct packed {
        logic       reset_high;
        logic       strobe_enable;
        logic       latch_program_pulse;
        logic       prog_voltage;
        logic       access_high;
        logic [3:0] mode_select;
    } prog_pins_t;

    // Lock state as seen by the run-time protection logic.
    typedef struct packed {
        logic block_table_read;
        logic ext_access_latched;
        logic block_write;
        logic block_verify;
        logic block_external_exec;
    } protect_t;

endpackage

// *** otp_code_mem.sv ***
/*
 * Code memory array of the one-time-programmable store, with registered read data.
 * A write may only clear bits: programming pulls erased ones to zero, as the
 * cells really behave. Assumes one clock; the array has no reset.
 */
`timescale 1ns/1ps
module otp_code_mem #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 8
) (
    input  wire logic              ref_clk_in,   // System clock.
    input  wire logic              wr_en_in,     // Program one byte.
    input  wire logic [ADDR_W-1:0] wr_addr_in,   // Program address.
    input  wire logic [DATA_W-1:0] wr_data_in,   // Program data.
    input  wire logic [ADDR_W-1:0] rd_addr_in,   // Read address.
    output logic      [DATA_W-1:0] rd_data_out   // Registered read data.
);
    logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];

    initial begin
        if (ADDR_W < 7 || DATA_W < 1) begin
            $error("otp_code_mem: unsupported geometry");
        end
        for (int i = 0; i < (1<<ADDR_W); i++) begin
            mem_q[i] = '1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= mem_q[wr_addr_in] & wr_data_in;
        end
        rd_data_out <= mem_q[rd_addr_in];
    end
endmodule

// *** otp_pin_sync.sv ***
/*
 * Two-stage synchroniser for a group of programming pins.
 * Assumes the pins are asynchronous to ref_clk_in.
 */
`timescale 1ns/1ps
module otp_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk_in,  // System clock.
    input  wire logic             rst_in,      // Synchronous reset.
    input  wire logic [WIDTH-1:0] async_in,    // Raw pin levels.
    output logic      [WIDTH-1:0] sync_out     // Synchronised levels.
);
    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) begin
            $error("otp_pin_sync: width must be positive");
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// *** otp_access_chk.sv ***
/*
 * Pin-level assertions for the OTP program and lock access block.
 * Assumes it is bound to otp_program_and_lock_access and sees only its ports.
 */
`timescale 1ns/1ps
`include "otp_prog_defs.svh"
module otp_access_chk #(
    parameter int         ADDR_W    = 13,
    parameter logic [7:0] SIG_MAKER = 8'h5a
) (
    input wire logic       ref_clk_in, rst_in, reset_pin_in, program_strobe_enable_in,        // Clock, reset, pins.
    input wire logic       latch_program_pulse_in, external_access_prog_voltage_in, external_access_pin_in, // Pins.
    input wire logic       mode_select_a_in, mode_select_b_in, mode_select_c_in, mode_select_d_in, // Selects.
    input wire logic [7:0] port1_in, port2_in, port0_out,                                     // Ports.
    input wire logic       port0_oe_out, table_read_from_external_in, table_read_allowed_out, // Port zero, table.
    input wire logic       external_exec_allowed_out, write_refused_out,                      // Protection.
    input wire logic [2:0] lock_bits_out                                                      // Lock state.
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    wire logic [3:0]  sel    = {mode_select_a_in, mode_select_b_in, mode_select_c_in, mode_select_d_in};
    wire logic [15:0] addr16 = {port2_in, port1_in};
    wire logic        rd_lvl = reset_pin_in && !program_strobe_enable_in && latch_program_pulse_in
                               && !external_access_prog_voltage_in && external_access_pin_in;
    wire logic        rd_code = rd_lvl && sel == `OTP_SEL_READ_CODE;
    wire logic        sig_30  = rd_lvl && sel == `OTP_SEL_SIGNATURE
                                && addr16[ADDR_W-1:0] == ADDR_W'(`OTP_SIG_ADDR_0);
    wire logic        lock12  = lock_bits_out[1:0] == 2'b11;

    AST_EXEC_OFF: assert property (external_exec_allowed_out == !(&lock_bits_out))
        else $error("external execution enable does not follow lock state");
    AST_TABLE_READ: assert property (table_read_allowed_out == !(lock_bits_out[0] && table_read_from_external_in))
        else $error("table read permission does not follow lock one");
    AST_NO_LOCK: assert property (lock_bits_out == 3'h0 |-> table_read_allowed_out && !write_refused_out)
        else $error("restriction active with no lock bit set");
    AST_LOCK_KEEP: assert property ((($past(lock_bits_out) & ~lock_bits_out) == 3'h0))
        else $error("a programmed lock bit was lost");
    AST_LOCK_ONE_AT_A_TIME: assert property ($changed(lock_bits_out)
        |-> $countones(lock_bits_out ^ $past(lock_bits_out)) == 1)
        else $error("more than one lock bit changed at once");
    AST_REFUSE_CAUSE: assert property ($rose(write_refused_out) |-> lock_bits_out[0])
        else $error("write refused without lock one");
    AST_VERIFY_BLOCK: assert property ((rd_code && lock12) [*6] |-> !port0_oe_out)
        else $error("verify read driven while locks one and two are set");
    AST_VERIFY_DRIVE: assert property ((rd_code && !lock12) [*6] |-> port0_oe_out)
        else $error("verify read not driven on port zero");
    AST_SIG_BYTE: assert property (sig_30 [*6] |-> port0_oe_out && port0_out == SIG_MAKER)
        else $error("signature byte at first location wrong");
    AST_NO_DRIVE_HV: assert property (external_access_prog_voltage_in [*6] |-> !port0_oe_out)
        else $error("port zero driven during programming");

    cover property ($rose(lock_bits_out[0]));
    cover property ($rose(write_refused_out));
    cover property ($fell(external_exec_allowed_out));
    cover property ($rose(port0_oe_out));
endmodule

bind otp_program_and_lock_access otp_access_chk #(.ADDR_W(ADDR_W), .SIG_MAKER(SIG_MAKER)) u_otp_access_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reset_pin_in(reset_pin_in),
    .program_strobe_enable_in(program_strobe_enable_in), .latch_program_pulse_in(latch_program_pulse_in),
    .external_access_prog_voltage_in(external_access_prog_voltage_in), .external_access_pin_in(external_access_pin_in),
    .mode_select_a_in(mode_select_a_in), .mode_select_b_in(mode_select_b_in), .mode_select_c_in(mode_select_c_in),
    .mode_select_d_in(mode_select_d_in), .port1_in(port1_in), .port2_in(port2_in), .port0_out(port0_out),
    .port0_oe_out(port0_oe_out), .table_read_from_external_in(table_read_from_external_in),
    .table_read_allowed_out(table_read_allowed_out), .external_exec_allowed_out(external_exec_allowed_out),
    .write_refused_out(write_refused_out), .lock_bits_out(lock_bits_out)
);

// *** otp_prog_model.sv ***
/*
 * Behavioural model of the external device programmer driving mode, address and data pins.
 * Assumes the testbench resolves port zero and calls these tasks from one process.
 */
`timescale 1ns/1ps
module otp_prog_model (
    input  wire logic        ref_clk_in,    // System clock.
    input  wire logic [7:0]  port0_wire_in, // Resolved port zero level.
    output logic             reset_pin_out, // Device reset pin.
    output logic             strobe_en_out, // Strobe enable pin.
    output logic             pulse_out,     // Latch/program pin.
    output logic             hv_out,        // High voltage on access pin.
    output logic             access_out,    // Access pin logic level.
    output logic [3:0]       sel_out,       // Mode selects a, b, c, d.
    output logic [15:0]      addr_out,      // Port two and port one.
    output logic [7:0]       data_out,      // Port zero drive value.
    output logic             data_en_out    // Port zero drive enable.
);
    initial begin
        {reset_pin_out, strobe_en_out, pulse_out, hv_out, access_out} = 5'b01100;
        {sel_out, addr_out, data_out, data_en_out} = '0;
    end

    // Sets a mode and waits out the setup time before any pulse or sample.
    task automatic setup(input logic [3:0] sel, input logic hv, input logic [15:0] addr, input logic [7:0] data);
        @(posedge ref_clk_in);
        reset_pin_out <= 1'b1;
        strobe_en_out <= 1'b0;
        pulse_out     <= 1'b1;
        hv_out        <= hv;
        access_out    <= 1'b1;
        sel_out       <= sel;
        addr_out      <= addr;
        data_out      <= data;
        data_en_out   <= hv;
        repeat (110) @(posedge ref_clk_in);
    endtask

    task automatic prog(input int cycles);
        @(posedge ref_clk_in);
        pulse_out <= 1'b0;
        repeat (cycles) @(posedge ref_clk_in);
        pulse_out <= 1'b1;
        repeat (110) @(posedge ref_clk_in);
    endtask

    task automatic read(input logic [3:0] sel, input logic [15:0] addr, output logic [7:0] data);
        setup(sel, 1'b0, addr, data_out);
        #1 data = port0_wire_in;
    endtask

    // Changes the reset and strobe-enable levels alone, then lets the synchronisers settle.
    task automatic set_env(input logic rst_lvl, input logic strobe_lvl);
        @(posedge ref_clk_in);
        reset_pin_out <= rst_lvl;
        strobe_en_out <= strobe_lvl;
        repeat (8) @(posedge ref_clk_in);
    endtask

    task automatic set_access(input logic lvl);
        @(posedge ref_clk_in);
        access_out <= lvl;
    endtask
endmodule

// *** testbench.sv ***
/*
 * Self-checking testbench of the OTP program and lock access block.
 * Assumes the programmer model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
module testbench;
    localparam logic [23:0] SIG_EXP = 24'h5aa53c; // Arbitrary values.
    logic        ref_clk_in, rst_in, tbl_ext, core_rel, reset_pin, strobe_en, pulse, hv, access, data_en;
    logic        port0_oe, tbl_ok, acc_eff, exec_ok, refused, busy;
    logic [3:0]  sel;
    logic [15:0] addr;
    logic [7:0]  data, port0_out, port0_wire, rd;
    logic [2:0]  lock_bits;
    int          errors, checks;

    // A released port zero shows the inverse of the programmer's data value.
    assign port0_wire = port0_oe ? port0_out : (data_en ? data : ~data);

    otp_program_and_lock_access #(.SIG_MAKER(SIG_EXP[23:16]), .SIG_KIND(SIG_EXP[15:8]), .SIG_EXTRA(SIG_EXP[7:0]))
    u_otp_program_and_lock_access (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reset_pin_in(reset_pin), .program_strobe_enable_in(strobe_en),
        .latch_program_pulse_in(pulse), .external_access_prog_voltage_in(hv), .external_access_pin_in(access),
        .mode_select_a_in(sel[3]), .mode_select_b_in(sel[2]), .mode_select_c_in(sel[1]), .mode_select_d_in(sel[0]),
        .port1_in(addr[7:0]), .port2_in(addr[15:8]), .port0_in(port0_wire), .port0_out(port0_out),
        .port0_oe_out(port0_oe), .table_read_from_external_in(tbl_ext), .core_reset_release_in(core_rel),
        .table_read_allowed_out(tbl_ok), .external_access_eff_out(acc_eff), .external_exec_allowed_out(exec_ok),
        .lock_bits_out(lock_bits), .write_refused_out(refused), .busy_out(busy)
    );

    otp_prog_model u_otp_prog_model (
        .ref_clk_in(ref_clk_in), .port0_wire_in(port0_wire), .reset_pin_out(reset_pin), .strobe_en_out(strobe_en),
        .pulse_out(pulse), .hv_out(hv), .access_out(access), .sel_out(sel), .addr_out(addr), .data_out(data),
        .data_en_out(data_en)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk_in);
        errors++;
        $display("[ERR] watchdog expected finish seen hang");
        wrap_up();
    end

    initial begin
        errors = 0;
        checks = 0;
        {rst_in, tbl_ext, core_rel} = 3'b100;
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        #1 chk("lock_bits", 8'h00, {5'h0, lock_bits});
        chk("exec_ok", 8'h01, {7'h0, exec_ok});
        u_otp_prog_model.read(4'h3, 16'h1234, rd);
        chk("erased", 8'hff, rd);
        u_otp_prog_model.setup(4'h7, 1'b1, 16'h1234, 8'h5c);
        u_otp_prog_model.prog(5000);
        u_otp_prog_model.read(4'h3, 16'h1234, rd);
        chk("written", 8'h5c, rd);
        u_otp_prog_model.set_env(1'b1, 1'b1);
        chk("strobe_high_idle", 8'h00, {7'h0, port0_oe});
        u_otp_prog_model.set_env(1'b0, 1'b0);
        chk("reset_low_idle", 8'h00, {7'h0, port0_oe});
        u_otp_prog_model.read(4'h3, 16'hf234, rd);
        chk("alias", 8'h5c, rd);
        u_otp_prog_model.read(4'h3, 16'h0234, rd);
        chk("neighbour", 8'hff, rd);
        for (int i = 0; i < 3; i++) begin
            u_otp_prog_model.read(4'h0, 16'h0030 + 16'(i), rd);
            chk("signature", SIG_EXP[23-8*i -: 8], rd);
        end
        u_otp_prog_model.setup(4'hf, 1'b1, 16'h0000, 8'h00);
        u_otp_prog_model.prog(100);
        chk("short_pulse", 8'h00, {5'h0, lock_bits});
        u_otp_prog_model.prog(5000);
        chk("lock_one", 8'h01, {5'h0, lock_bits});
        @(posedge ref_clk_in);
        tbl_ext <= 1'b1;
        #1 chk("table_ext", 8'h00, {7'h0, tbl_ok});
        @(posedge ref_clk_in);
        tbl_ext  <= 1'b0;
        core_rel <= 1'b1;
        @(posedge ref_clk_in);
        core_rel <= 1'b0;
        u_otp_prog_model.set_access(1'b0);
        repeat (4) @(posedge ref_clk_in);
        #1 chk("access_latched", 8'h01, {7'h0, acc_eff});
        u_otp_prog_model.setup(4'h7, 1'b1, 16'h0100, 8'h00);
        u_otp_prog_model.prog(5000);
        chk("refused", 8'h01, {7'h0, refused});
        u_otp_prog_model.read(4'h3, 16'h0100, rd);
        chk("not_written", 8'hff, rd);
        u_otp_prog_model.setup(4'hc, 1'b1, 16'h0000, 8'h00);
        u_otp_prog_model.prog(5000);
        chk("lock_two", 8'h03, {5'h0, lock_bits});
        u_otp_prog_model.read(4'h3, 16'h1234, rd);
        chk("verify_off", 8'h00, {7'h0, port0_oe});
        u_otp_prog_model.read(4'h0, 16'h0030, rd);
        chk("sig_locked", SIG_EXP[23:16], rd);
        u_otp_prog_model.setup(4'ha, 1'b1, 16'h0000, 8'h00);
        u_otp_prog_model.prog(5000);
        chk("lock_three", 8'h07, {5'h0, lock_bits});
        chk("exec_off", 8'h00, {7'h0, exec_ok});
        wrap_up();
    end
endmodule
